/* core/adcss_pkg.sv */
package adcss_pkg;

  // --------------------------------------------------------------------
  // sequence geometry
  // --------------------------------------------------------------------
  localparam int SLOT_W = 6;
  localparam int NUM_SLOTS = 64;
  localparam int CHAN_W = 5;
  localparam int OP_W = 3;
  localparam int ENTRY_W = 14;
  localparam int OP_LSB = 0;
  localparam int CHAN_LSB = 3;
  localparam int TGT_LSB = 8;

  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam int CAL_CONV_CLOCKS = 3840;
  localparam int CONV_CLK_DIV = 1;
  localparam int CAL_CYCLES = CAL_CONV_CLOCKS * CONV_CLK_DIV;
  localparam logic [CNT_W-1:0] CAL_LOAD = CNT_W'(CAL_CYCLES - 1);
  localparam logic [CNT_W-1:0] CONVT_RESET = 16'h0010;

  // --------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] CONVT_ADDR = 12'h004;
  localparam logic [3:0] SLOT_PAGE = 4'h1;
  localparam int STAT_SLOT_LSB = 0;
  localparam int STAT_STATE_LSB = 8;
  localparam int STAT_PD_BIT = 12;
  localparam int STAT_DONE_BIT = 13;
  localparam int STAT_JPEND_BIT = 14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_IDLE,
    OP_SAMPLE,
    OP_SAMPLE_JUMP,
    OP_CAL,
    OP_CAL_JUMP,
    OP_JUMP,
    OP_PDOWN,
    OP_STOP
  } adcss_op_t;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_SAMPLE,
    ST_CAL,
    ST_END,
    ST_WAIT,
    ST_HALT
  } adcss_state_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } adcss_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } adcss_axi_rsp_t;

  typedef struct packed {
    adcss_state_t st;
    logic [SLOT_W-1:0] slot;
    logic [SLOT_W-1:0] jtgt;
    logic jpend;
    logic pwr_dn;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] conv_t;
    logic [NUM_SLOTS-1:0][ENTRY_W-1:0] mem;
    logic [CHAN_W-1:0] chan;
    logic samp;
    logic cal;
    logic [CNT_W-1:0] cal_len;
    logic aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } adcss_regs_t;

endpackage : adcss_pkg

/* core/adcss_sequencer.sv */
// Operation
// - sample slot converts its channel, then moves to the next slot
// - sample-and-jump converts its channel, then continues at the slot's target
// - calibrate runs 3840 converter clocks, then moves to the next slot
// - calibrate-and-jump calibrates, then continues at the slot's target
// - jump slot goes straight to its target, no sample, no calibration
// - power-down powers converter off; no sampling until a calibration runs
// - stop halts until an external trigger restarts it
// - idle slot does nothing and advances; trailing idle slots are stepped through up to slot 63
// - manual mode finishes the slot, then waits for a trigger pulse
// - auto mode advances every slot, wrapping 63 to 0
// - auto mode halts at stop or power-down until a jump elsewhere
// - all control inputs and status outputs are active high
// - manual trigger is a one-cycle pulse that runs the current slot
// - in auto mode the trigger input is ignored
// - jump enable moves to the target slot once the current slot completes
// - current slot number is shown on a 6-bit output
// - slot change warning precedes the edge that changes the slot output
// - channel number and sample flag show the conversion in progress
// - after reset execution starts at slot 0
// - sequence memory holds 64 slots
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module adcss_sequencer
  import adcss_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  input wire adcss_axi_req_t AXI_REQ_I,
  output adcss_axi_rsp_t AXI_RSP_O,
  input wire logic EXT_STEP_MODE_I,
  input wire logic EXT_STEP_PULSE_I,
  input wire logic SLOT_JUMP_ENABLE_I,
  input wire logic [SLOT_W-1:0] JUMP_TARGET_SLOT_I,
  output logic [SLOT_W-1:0] CURRENT_SLOT_O,
  output logic SLOT_CHANGE_WARN_O,
  output logic [CHAN_W-1:0] CONV_CHANNEL_NUM_O,
  output logic SAMPLE_ACTIVE_O,
  output logic CAL_ACTIVE_O,
  output logic POWER_DOWN_O,
  output logic DONE_O
);

  // --------------------------------------------------------------------
  // state and decode
  // --------------------------------------------------------------------
  adcss_regs_t r;
  adcss_regs_t next_r;
  logic [ENTRY_W-1:0] ent;
  adcss_op_t op;
  logic [CHAN_W-1:0] ent_chan;
  logic [SLOT_W-1:0] ent_tgt;
  logic slot_upd;
  logic [SLOT_W-1:0] slot_nxt;
  logic done;
  logic awready;
  logic wready;
  logic arready;
  logic [31:0] wr_word;
  logic [31:0] rd_word;
  logic [1:0] rd_resp;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  assign ent = r.mem[r.slot];
  assign op = adcss_op_t'(ent[OP_LSB +: OP_W]);
  assign ent_chan = ent[CHAN_LSB +: CHAN_W];
  assign ent_tgt = ent[TGT_LSB +: SLOT_W];
  assign awready = !r.aw_got && !r.bvalid;
  assign wready = !r.w_got && !r.bvalid;
  assign arready = !r.rvalid;

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    slot_upd = 1'b0;
    slot_nxt = r.slot;
    done = 1'b0;
    wr_word = 32'h0000_0000;
    rd_word = 32'h0000_0000;
    rd_resp = RESP_OKAY;
    if (r.cal)
    begin
      next_r.cal_len = r.cal_len + 16'h0001;
    end
    case (r.st)
      ST_RUN:
      begin
        case (op)
          OP_SAMPLE, OP_SAMPLE_JUMP:
          begin
            if (r.pwr_dn)
            begin
              next_r.st = ST_END;
            end
            else
            begin
              next_r.st = ST_SAMPLE;
              next_r.cnt = r.conv_t;
              next_r.samp = 1'b1;
              next_r.chan = ent_chan;
            end
          end
          OP_CAL, OP_CAL_JUMP:
          begin
            next_r.st = ST_CAL;
            next_r.cnt = CAL_LOAD;
            next_r.cal = 1'b1;
            next_r.cal_len = 16'h0000;
          end
          OP_PDOWN:
          begin
            next_r.pwr_dn = 1'b1;
            next_r.st = ST_HALT;
          end
          OP_STOP:
          begin
            next_r.st = ST_HALT;
          end
          default:
          begin
            next_r.st = ST_END;
          end
        endcase
      end
      ST_SAMPLE:
      begin
        if (r.cnt == 16'h0000)
        begin
          next_r.samp = 1'b0;
          next_r.st = ST_END;
        end
        else
        begin
          next_r.cnt = r.cnt - 16'h0001;
        end
      end
      ST_CAL:
      begin
        if (r.cnt == 16'h0000)
        begin
          next_r.cal = 1'b0;
          next_r.pwr_dn = 1'b0;
          next_r.st = ST_END;
        end
        else
        begin
          next_r.cnt = r.cnt - 16'h0001;
        end
      end
      ST_END:
      begin
        slot_upd = 1'b1;
        next_r.jpend = 1'b0;
        if (r.jpend)
        begin
          slot_nxt = r.jtgt;
        end
        else if (op == OP_SAMPLE_JUMP || op == OP_CAL_JUMP || op == OP_JUMP)
        begin
          slot_nxt = ent_tgt;
        end
        else
        begin
          slot_nxt = r.slot + 6'h01;
        end
        next_r.st = EXT_STEP_MODE_I ? ST_WAIT : ST_RUN;
      end
      ST_WAIT:
      begin
        done = 1'b1;
        if (r.jpend)
        begin
          slot_upd = 1'b1;
          slot_nxt = r.jtgt;
          next_r.jpend = 1'b0;
        end
        if (!EXT_STEP_MODE_I || EXT_STEP_PULSE_I)
        begin
          next_r.st = ST_RUN;
        end
      end
      ST_HALT:
      begin
        done = EXT_STEP_MODE_I;
        next_r.jpend = 1'b0;
        if (r.jpend && r.jtgt != r.slot)
        begin
          slot_upd = 1'b1;
          slot_nxt = r.jtgt;
          next_r.st = ST_RUN;
        end
        else if (EXT_STEP_MODE_I && EXT_STEP_PULSE_I)
        begin
          slot_upd = 1'b1;
          slot_nxt = r.slot + 6'h01;
          next_r.st = ST_RUN;
        end
      end
      default:
      begin
        next_r.st = ST_RUN;
      end
    endcase
    if (slot_upd)
    begin
      next_r.slot = slot_nxt;
    end
    if (SLOT_JUMP_ENABLE_I)
    begin
      next_r.jpend = 1'b1;
      next_r.jtgt = JUMP_TARGET_SLOT_I;
    end

    // register bus: write path
    if (AXI_REQ_I.awvalid && awready)
    begin
      next_r.aw_got = 1'b1;
      next_r.awaddr = AXI_REQ_I.awaddr;
    end
    if (AXI_REQ_I.wvalid && wready)
    begin
      next_r.w_got = 1'b1;
      next_r.wdata = AXI_REQ_I.wdata;
      next_r.wstrb = AXI_REQ_I.wstrb;
    end
    if (r.aw_got && r.w_got)
    begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      if (r.awaddr[ADDR_W-1:8] == SLOT_PAGE)
      begin
        wr_word = merge_bytes({18'h00000, r.mem[r.awaddr[7:2]]}, r.wdata, r.wstrb);
        next_r.mem[r.awaddr[7:2]] = wr_word[ENTRY_W-1:0];
      end
      else if (r.awaddr == CONVT_ADDR)
      begin
        wr_word = merge_bytes({16'h0000, r.conv_t}, r.wdata, r.wstrb);
        next_r.conv_t = wr_word[CNT_W-1:0];
      end
      else if (r.awaddr != STATUS_ADDR)
      begin
        next_r.bresp = RESP_SLVERR;
      end
    end
    if (r.bvalid && AXI_REQ_I.bready)
    begin
      next_r.bvalid = 1'b0;
    end

    // register bus: read path
    if (AXI_REQ_I.araddr[ADDR_W-1:8] == SLOT_PAGE)
    begin
      rd_word[ENTRY_W-1:0] = r.mem[AXI_REQ_I.araddr[7:2]];
    end
    else if (AXI_REQ_I.araddr == CONVT_ADDR)
    begin
      rd_word[CNT_W-1:0] = r.conv_t;
    end
    else if (AXI_REQ_I.araddr == STATUS_ADDR)
    begin
      rd_word[STAT_SLOT_LSB +: SLOT_W] = r.slot;
      rd_word[STAT_STATE_LSB +: 3] = r.st;
      rd_word[STAT_PD_BIT] = r.pwr_dn;
      rd_word[STAT_DONE_BIT] = done;
      rd_word[STAT_JPEND_BIT] = r.jpend;
    end
    else
    begin
      rd_resp = RESP_SLVERR;
    end
    if (r.rvalid && AXI_REQ_I.rready)
    begin
      next_r.rvalid = 1'b0;
    end
    if (AXI_REQ_I.arvalid && arready)
    begin
      next_r.rvalid = 1'b1;
      next_r.rdata = rd_word;
      next_r.rresp = rd_resp;
    end
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      r <= '0;
      r.st <= ST_RUN;
      r.conv_t <= CONVT_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign CURRENT_SLOT_O = r.slot;
  assign SLOT_CHANGE_WARN_O = slot_upd && (slot_nxt != r.slot);
  assign CONV_CHANNEL_NUM_O = r.chan;
  assign SAMPLE_ACTIVE_O = r.samp;
  assign CAL_ACTIVE_O = r.cal;
  assign POWER_DOWN_O = r.pwr_dn;
  assign DONE_O = done;
  assign AXI_RSP_O.awready = awready;
  assign AXI_RSP_O.wready = wready;
  assign AXI_RSP_O.bvalid = r.bvalid;
  assign AXI_RSP_O.bresp = r.bresp;
  assign AXI_RSP_O.arready = arready;
  assign AXI_RSP_O.rvalid = r.rvalid;
  assign AXI_RSP_O.rdata = r.rdata;
  assign AXI_RSP_O.rresp = r.rresp;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  slot_warn_a: assert property (SLOT_CHANGE_WARN_O |=> CURRENT_SLOT_O != $past(CURRENT_SLOT_O))
    else $error("slot did not change after warning");
  slot_quiet_a: assert property (!SLOT_CHANGE_WARN_O |=> $stable(CURRENT_SLOT_O))
    else $error("slot changed without warning");
  cal_length_a: assert property ($fell(CAL_ACTIVE_O) |-> r.cal_len == CNT_W'(CAL_CYCLES))
    else $error("calibration length wrong");
  pd_block_a: assert property (POWER_DOWN_O |-> !SAMPLE_ACTIVE_O)
    else $error("sampling while powered down");
  auto_step_a: assert property ((!EXT_STEP_MODE_I && r.st == ST_WAIT) |=> r.st == ST_RUN)
    else $error("auto mode stalled on trigger");
  manual_hold_a: assert property ((EXT_STEP_MODE_I && !EXT_STEP_PULSE_I && r.st == ST_WAIT)
                                  |=> r.st == ST_WAIT)
    else $error("manual mode advanced without trigger");
  slot_wrap_a: assert property ((r.st == ST_END && !r.jpend && r.slot == 6'h3F
                                 && !(op inside {OP_SAMPLE_JUMP, OP_CAL_JUMP, OP_JUMP}))
                                |=> CURRENT_SLOT_O == 6'h00)
    else $error("slot did not wrap to zero");
  auto_halt_a: assert property ((r.st == ST_HALT && !EXT_STEP_MODE_I && !r.jpend)
                                |=> r.st == ST_HALT && $stable(CURRENT_SLOT_O))
    else $error("halt left without jump");
  jump_take_a: assert property ((r.st == ST_END && r.jpend) |=> CURRENT_SLOT_O == $past(r.jtgt))
    else $error("pending jump not honoured");
  samp_chan_a: assert property ($rose(SAMPLE_ACTIVE_O) |-> CONV_CHANNEL_NUM_O == $past(ent_chan))
    else $error("channel number mismatch");
  halt_step_a: assert property ((r.st == ST_HALT && EXT_STEP_MODE_I && EXT_STEP_PULSE_I && !r.jpend)
                                |=> r.st == ST_RUN && CURRENT_SLOT_O == $past(CURRENT_SLOT_O) + 6'h01)
    else $error("stop not restarted by trigger");
  cal_wake_a: assert property ($fell(CAL_ACTIVE_O) |-> !POWER_DOWN_O)
    else $error("power-down kept after calibration");
  wait_done_a: assert property ((r.st == ST_WAIT) |-> DONE_O)
    else $error("done low while waiting for trigger");

endmodule : adcss_sequencer

`default_nettype wire

/* dv/adcss_user_model.sv */
`timescale 1ns/100ps
`default_nettype none

module adcss_user_model
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic done_i,
  output logic pulse_o
);
  logic [3:0] dly;
  logic [1:0] n;

  // ----
  // stepping user logic, 9 to 12 cycles behind done
  // ----
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pulse_o <= 1'b0;
      dly <= 4'h8;
      n <= 2'h0;
    end
    else if (pulse_o)
    begin
      pulse_o <= 1'b0;
      n <= n + 2'h1;
      dly <= 4'h8 + 4'(n);
    end
    else if (en_i && done_i)
    begin
      if (dly == 4'h0)
        pulse_o <= 1'b1;
      else
        dly <= dly - 4'h1;
    end
  end
endmodule : adcss_user_model

`default_nettype wire

/* dv/adcss_sequencer_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module adcss_sequencer_tb_top
  import adcss_pkg::*;
;
  logic clk, rst, mode, tb_pulse, jen, pm_en, pm_pulse, w_q, m_jp, m_pd;
  logic warn, samp, cal, pd, done;
  logic [5:0] jtgt, cur, m_slot, m_jt, t6;
  logic [4:0] chn;
  logic [13:0] mm [64];
  logic [31:0] m_conv, rd;
  int n_fail, n_compared, seed, sc, cc, t;
  adcss_axi_req_t req;
  adcss_axi_rsp_t rsp;

  adcss_sequencer u_adcss_sequencer (.REF_CLK_I(clk), .SYS_RST_I(rst), .AXI_REQ_I(req), .AXI_RSP_O(rsp),
    .EXT_STEP_MODE_I(mode), .EXT_STEP_PULSE_I(pm_pulse | tb_pulse), .SLOT_JUMP_ENABLE_I(jen),
    .JUMP_TARGET_SLOT_I(jtgt), .CURRENT_SLOT_O(cur), .SLOT_CHANGE_WARN_O(warn), .CONV_CHANNEL_NUM_O(chn),
    .SAMPLE_ACTIVE_O(samp), .CAL_ACTIVE_O(cal), .POWER_DOWN_O(pd), .DONE_O(done));

  adcss_user_model u_adcss_user_model (.clk_i(clk), .rst_i(rst), .en_i(pm_en), .done_i(done),
    .pulse_o(pm_pulse));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----
  // shared tasks
  // ----
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    n_compared++;
    if (s !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t %s: saw %0h expected %0h", $time, m, s, e);
    end
  endtask : chk

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    int k;
    aw = 1'b1;
    w = 1'b1;
    k = 0;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (aw && rsp.awready)
      begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready)
      begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
      k++;
    end while (rsp.bvalid !== 1'b1 && k < 100);
    chk(32'(rsp.bvalid), 32'h1, "write answer");
    chk(32'(rsp.bresp), 32'(er), "write response");
    req.bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      k++;
    end while (rsp.rvalid !== 1'b1 && k < 100);
    d = rsp.rdata;
    chk(32'(rsp.rvalid), 32'h1, "read answer");
    chk(32'(rsp.rresp), 32'(er), "read response");
    req.rready <= 1'b0;
  endtask : axr

  task automatic ld(input logic [5:0] s, input adcss_op_t op, input logic [4:0] ch, input logic [5:0] tg);
    mm[s] = {tg, ch, op};
    axw({SLOT_PAGE, s, 2'b00}, 32'(mm[s]), RESP_OKAY);
  endtask : ld

  task automatic jmp(input logic [5:0] s);
    @(posedge clk);
    jen <= 1'b1;
    jtgt <= s;
    m_jp = 1'b1;
    m_jt = s;
    @(posedge clk);
    jen <= 1'b0;
  endtask : jmp

  task automatic wait_slot(input logic [5:0] s);
    t = 0;
    while (m_slot !== s && t < 20000)
    begin
      @(posedge clk);
      t++;
    end
    chk(32'(m_slot), 32'(s), "slot not reached");
  endtask : wait_slot

  function automatic logic [5:0] nx();
    logic [13:0] e;
    e = mm[m_slot];
    if (m_jp)
      return m_jt;
    if (e[2:0] inside {OP_SAMPLE_JUMP, OP_CAL_JUMP, OP_JUMP})
      return e[13:8];
    return m_slot + 6'h1;
  endfunction : nx

  // ----
  // behavioural model of slot flow
  // ----
  always @(posedge clk)
  begin
    if (rst)
    begin
      w_q = 1'b0;
      m_slot = 6'h0;
      for (int i = 0; i < 64; i++)
        mm[i] = 14'h0;
      m_jp = 1'b0;
      m_pd = 1'b0;
      sc = 0;
      cc = 0;
    end
    else
    begin
      if (w_q)
      begin
        t6 = nx();
        chk(32'(cur), 32'(t6), "slot after change");
        if (mm[m_slot][2:0] == OP_PDOWN)
          m_pd = 1'b1;
        else if (mm[m_slot][2:0] inside {OP_CAL, OP_CAL_JUMP})
          m_pd = 1'b0;
        m_slot = t6;
        m_jp = 1'b0;
        chk(32'(pd), 32'(m_pd), "power-down state");
      end
      else
        chk(32'(cur), 32'(m_slot), "slot moved unwarned");
      w_q = warn;
      if (samp)
      begin
        chk(32'(chn), 32'(mm[m_slot][7:3]), "channel");
        chk(32'(m_pd), 32'h0, "sample while powered down");
        sc++;
      end
      else if (sc != 0)
      begin
        chk(32'(sc), m_conv + 32'h1, "sample length");
        sc = 0;
      end
      if (cal)
        cc++;
      else if (cc != 0)
      begin
        chk(32'(cc), 32'(CAL_CYCLES), "calibration length");
        cc = 0;
      end
    end
  end

  initial
  begin
    #240000;
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test;
  end

  // ----
  // main sequence
  // ----
  initial
  begin
    seed = 5998;
    n_fail = 0;
    n_compared = 0;
    {mode, tb_pulse, jen, jtgt, pm_en} = {1'b1, 9'h0};
    req = '0;
    rst = 1'b1;
    m_conv = 32'(CONVT_RESET);
    for (int i = 0; i < 64; i++)
      mm[i] = 14'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    axr(CONVT_ADDR, rd, RESP_OKAY);
    chk(rd, 32'(CONVT_RESET), "conv time reset");
    axr(12'h008, rd, RESP_SLVERR);
    axw(12'h008, 32'h1, RESP_SLVERR);
    axw(STATUS_ADDR, 32'hFFFF, RESP_OKAY);
    ld(6'd1, OP_SAMPLE, 5'($random(seed)), 6'd0);
    ld(6'd2, OP_CAL, 5'h0, 6'd0);
    ld(6'd3, OP_SAMPLE_JUMP, 5'($random(seed)), 6'd6);
    ld(6'd6, OP_PDOWN, 5'h0, 6'd0);
    ld(6'd7, OP_SAMPLE, 5'($random(seed)), 6'd0);
    ld(6'd8, OP_CAL_JUMP, 5'h0, 6'd10);
    ld(6'd10, OP_SAMPLE, 5'($random(seed)), 6'd0);
    ld(6'd11, OP_JUMP, 5'h0, 6'd13);
    ld(6'd13, OP_STOP, 5'h0, 6'd0);
    axr({SLOT_PAGE, 6'd3, 2'b00}, rd, RESP_OKAY);
    chk(rd, 32'(mm[3]), "slot entry readback");
    axr(STATUS_ADDR, rd, RESP_OKAY);
    chk(rd, 32'h2401, "status while waiting");
    chk(32'(done), 32'h1, "done while waiting");
    $display("test registers done");
    pm_en <= 1'b1;
    wait_slot(6'd13);
    pm_en <= 1'b0;
    $display("test manual stepping done");
    repeat (4) @(posedge clk);
    mode <= 1'b0;
    axw(CONVT_ADDR, 32'h28, RESP_OKAY);
    m_conv = 32'h28;
    axr(STATUS_ADDR, rd, RESP_OKAY);
    chk(rd, 32'h050D, "status halted in auto");
    repeat (32)
    begin
      @(posedge clk);
      tb_pulse <= 1'($random(seed));
    end
    @(posedge clk);
    tb_pulse <= 1'b0;
    chk(32'(m_slot), 32'd13, "trigger ignored in auto");
    jmp(6'd1);
    wait_slot(6'd6);
    repeat (40) @(posedge clk);
    chk(32'(m_slot), 32'd6, "halt at power-down");
    jmp(6'd7);
    wait_slot(6'd10);
    t = 0;
    while (samp !== 1'b1 && t < 100)
    begin
      @(posedge clk);
      t++;
    end
    chk(32'(samp), 32'h1, "sample start");
    jmp(6'd20);
    wait_slot(6'd6);
    $display("test auto forwarding done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wait_slot(6'd6);
    $display("test mid-run reset done");
    end_of_test;
  end
endmodule : adcss_sequencer_tb_top

`default_nettype wire
